// [rtl/port_pin_function_select.sv]
// Purpose: pin function multiplexer for pins B4-B7, C0-C7, D0-D7, E0-E7, F0-F5
// Assumes: 25 MHz i_clk; pin index 0 is B4, counting up to F5 at 33
// Notes: pin outputs are registered, so every route adds one cycle
//
// Notes on behaviour
// - B5 high field: port, keyboard 5, spi0 select, i2c data; rest reserved.
// - B4 low field: port, keyboard 4, spi0 clock, i2c clock; rest reserved.
// - B7 high field: port, keyboard 7, uart2 transmit, segment 1.
// - B6 low field: port, keyboard 6, uart2 receive, segment 0.
// - C1/C0: port, spi1 miso/mosi, segments 3/2; 011 up reserved.
// - C3/C2: port, spi1 select/clock, segments 5/4; 011 up reserved.
// - C5/C4: port, timer channels, uart1 tx/rx, segments 7/6.
// - C7/C6: port, pulse counter channels, uart3 tx/rx, segments 9/8.
// - D1/D0: port, keyboard 1/0, spi2 miso/mosi, segments 11/10.
// - D3/D2: port, keyboard 3/2, spi2 select/clock, segments 13/12.
// - D5: clock output at 010, segment 15; D4: segment 14 at 010.
// - D7/D6: port, keyboard 7/6, segments 17/16; 011 up reserved.
// - E1/E0: port or segments 19/18; 010 up reserved.
// - E3/E2: port or segments 21/20; 010 up reserved.
// - E5/E4: port, 001 reserved, segments 23/22 at 010.
// - E7/E6: port, 001 reserved, segments 25/24 at 010.
// - F1/F0: port or segments 27/26; 010 up reserved.
// - F3/F2: port or segments 29/28; 010 up reserved.
// - F5/F4: port or segments 31/30; 010 up reserved.
// - every function register resets to zero, all pins plain port.
// - port input path sees the pin for every selection.
`timescale 1ns/1ps
`default_nettype none
`include "pin_function_defs.svh"

module port_pin_function_select #(
  parameter int PIN_COUNT = `PF_PIN_COUNT
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`PF_ADDR_W-1:0] i_wb_adr,
  input wire logic [`PF_DATA_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [`PF_DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [PIN_COUNT-1:0] i_pin_in,
  output logic [PIN_COUNT-1:0] o_pin_out,
  output logic [PIN_COUNT-1:0] o_pin_oe,
  input wire logic [PIN_COUNT-1:0] i_port_out,
  input wire logic [PIN_COUNT-1:0] i_port_oe,
  output logic [PIN_COUNT-1:0] o_port_in,
  input wire pin_function_pkg::periph_drive_t i_periph_drive,
  output pin_function_pkg::periph_sense_t o_periph_sense
);

  localparam int B4 = 0;
  localparam int B5 = 1;
  localparam int B6 = 2;
  localparam int B7 = 3;
  localparam int C0 = 4;
  localparam int C1 = 5;
  localparam int C2 = 6;
  localparam int C3 = 7;
  localparam int C4 = 8;
  localparam int C5 = 9;
  localparam int C6 = 10;
  localparam int C7 = 11;
  localparam int D0 = 12;
  localparam int D1 = 13;
  localparam int D2 = 14;
  localparam int D3 = 15;
  localparam int D4 = 16;
  localparam int D5 = 17;
  localparam int D6 = 18;
  localparam int D7 = 19;
  localparam int E0 = 20;
  localparam int E4 = 24;
  localparam int E7 = 27;
  localparam int F0 = 28;

  logic rst_meta_r;
  logic rst_sync_r;
  logic [PIN_COUNT-1:0] pin_meta_r;
  logic [PIN_COUNT-1:0] pin_sync_r;
  logic [PIN_COUNT-1:0] pin_out_r;
  logic [PIN_COUNT-1:0] pin_oe_r;
  logic [PIN_COUNT-1:0] pin_out_nxt;
  logic [PIN_COUNT-1:0] pin_oe_nxt;
  logic [PIN_COUNT-1:0] rsvd;
  pin_function_pkg::pin_sel_t [PIN_COUNT-1:0] sel;
  pin_function_pkg::periph_sense_t sense_r;
  pin_function_pkg::periph_sense_t sense_nxt;
  pin_function_pkg::periph_drive_t pd;

  assign pd = i_periph_drive;

  // reset enters asynchronously, leaves synchronously
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  pin_function_regs u_regs (
    .i_clk(i_clk),
    .i_rst_n(rst_sync_r),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat),
    .i_wb_sel(i_wb_sel),
    .i_reserved_any(|rsvd),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .o_sel(sel)
  );

  // segment drive code per pin, port only where a pin has no segment line
  function automatic logic [2:0] seg_code(input int p);
    if (p < B6) begin
      seg_code = `PF_CODE_PORT;
    end else if (p < C0) begin
      seg_code = `PF_CODE_ALT3;
    end else if (p < C4) begin
      seg_code = `PF_CODE_ALT2;
    end else if (p < D4) begin
      seg_code = `PF_CODE_ALT3;
    end else if (p == D5) begin
      seg_code = `PF_CODE_ALT3;
    end else if (p < E0) begin
      seg_code = `PF_CODE_ALT2;
    end else if (p < E4) begin
      seg_code = `PF_CODE_ALT1;
    end else if (p < F0) begin
      seg_code = `PF_CODE_ALT2;
    end else begin
      seg_code = `PF_CODE_ALT1;
    end
  endfunction

  // highest defined code per pin; E4-E7 also hold 001 reserved
  function automatic logic is_reserved(input int p, input logic [2:0] c);
    logic [2:0] top;
    top = seg_code(p);
    if (p < B6 || p == D4 || (p >= C4 && p < D4)) begin
      top = `PF_CODE_ALT3;
    end
    if (p == D4) begin
      top = `PF_CODE_ALT2;
    end
    is_reserved = (c > top) || (p >= E4 && p <= E7 && c == `PF_CODE_ALT1);
  endfunction

  function automatic logic tap(input logic [2:0] s, input logic lvl, input logic [2:0] c);
    tap = (s == c) & lvl;
  endfunction

  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      rsvd[p] = is_reserved(p, sel[p]);
    end
  end

  // two flops on every pin before anything looks at it
  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= i_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // input buffer never gated by the selection
  assign o_port_in = pin_sync_r;

  // output routing; reserved codes fall through with no drive
  always_comb begin
    pin_out_nxt = '0;
    pin_oe_nxt = '0;
    for (int p = 0; p < PIN_COUNT; p++) begin
      if (sel[p] == `PF_CODE_PORT) begin
        pin_out_nxt[p] = i_port_out[p];
        pin_oe_nxt[p] = i_port_oe[p];
      end else if (!rsvd[p]) begin
        if (p >= `PF_SEG_PIN_BASE && sel[p] == seg_code(p)) begin
          pin_out_nxt[p] = pd.segment_line[p - `PF_SEG_PIN_BASE];
          pin_oe_nxt[p] = 1'b1;
        end
        case (p)
          B4: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi0_sclk;
            end else if (sel[p] == `PF_CODE_ALT3) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.i2c_scl;
            end
          end
          B5: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi0_ss;
            end else if (sel[p] == `PF_CODE_ALT3) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.i2c_sda;
            end
          end
          B7: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              pin_out_nxt[p] = pd.uart2_tx;
              pin_oe_nxt[p] = 1'b1;
            end
          end
          C0: begin
            if (sel[p] == `PF_CODE_ALT1) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi1.mosi;
            end
          end
          C1: begin
            if (sel[p] == `PF_CODE_ALT1) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi1.miso;
            end
          end
          C2: begin
            if (sel[p] == `PF_CODE_ALT1) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi1.sclk;
            end
          end
          C3: begin
            if (sel[p] == `PF_CODE_ALT1) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi1.ss;
            end
          end
          C4: begin
            if (sel[p] == `PF_CODE_ALT1) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.timer_channel_0;
            end
          end
          C5: begin
            if (sel[p] == `PF_CODE_ALT1) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.timer_channel_1;
            end else if (sel[p] == `PF_CODE_ALT2) begin
              pin_out_nxt[p] = pd.uart1_tx;
              pin_oe_nxt[p] = 1'b1;
            end
          end
          C7: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              pin_out_nxt[p] = pd.uart3_tx;
              pin_oe_nxt[p] = 1'b1;
            end
          end
          D0: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi2.mosi;
            end
          end
          D1: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi2.miso;
            end
          end
          D2: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi2.sclk;
            end
          end
          D3: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              {pin_out_nxt[p], pin_oe_nxt[p]} = pd.spi2.ss;
            end
          end
          D5: begin
            if (sel[p] == `PF_CODE_ALT2) begin
              pin_out_nxt[p] = pd.system_clock_output;
              pin_oe_nxt[p] = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // input-only functions leave drive off; peripherals see zero when not routed
  always_comb begin
    sense_nxt = '0;
    sense_nxt.keyboard_input[0] = tap(sel[D0], pin_sync_r[D0], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[1] = tap(sel[D1], pin_sync_r[D1], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[2] = tap(sel[D2], pin_sync_r[D2], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[3] = tap(sel[D3], pin_sync_r[D3], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[4] = tap(sel[B4], pin_sync_r[B4], `PF_CODE_ALT1) |
                                  tap(sel[D4], pin_sync_r[D4], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[5] = tap(sel[B5], pin_sync_r[B5], `PF_CODE_ALT1) |
                                  tap(sel[D5], pin_sync_r[D5], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[6] = tap(sel[B6], pin_sync_r[B6], `PF_CODE_ALT1) |
                                  tap(sel[D6], pin_sync_r[D6], `PF_CODE_ALT1);
    sense_nxt.keyboard_input[7] = tap(sel[B7], pin_sync_r[B7], `PF_CODE_ALT1) |
                                  tap(sel[D7], pin_sync_r[D7], `PF_CODE_ALT1);
    sense_nxt.spi0_sclk = tap(sel[B4], pin_sync_r[B4], `PF_CODE_ALT2);
    sense_nxt.i2c_scl = tap(sel[B4], pin_sync_r[B4], `PF_CODE_ALT3);
    sense_nxt.spi0_ss = tap(sel[B5], pin_sync_r[B5], `PF_CODE_ALT2);
    sense_nxt.i2c_sda = tap(sel[B5], pin_sync_r[B5], `PF_CODE_ALT3);
    sense_nxt.uart2_rx = tap(sel[B6], pin_sync_r[B6], `PF_CODE_ALT2);
    sense_nxt.spi1.mosi = tap(sel[C0], pin_sync_r[C0], `PF_CODE_ALT1);
    sense_nxt.spi1.miso = tap(sel[C1], pin_sync_r[C1], `PF_CODE_ALT1);
    sense_nxt.spi1.sclk = tap(sel[C2], pin_sync_r[C2], `PF_CODE_ALT1);
    sense_nxt.spi1.ss = tap(sel[C3], pin_sync_r[C3], `PF_CODE_ALT1);
    sense_nxt.timer_channel_0 = tap(sel[C4], pin_sync_r[C4], `PF_CODE_ALT1);
    sense_nxt.timer_channel_1 = tap(sel[C5], pin_sync_r[C5], `PF_CODE_ALT1);
    sense_nxt.uart1_rx = tap(sel[C4], pin_sync_r[C4], `PF_CODE_ALT2);
    sense_nxt.pulse_counter_channel_0 = tap(sel[C6], pin_sync_r[C6], `PF_CODE_ALT1);
    sense_nxt.pulse_counter_channel_1 = tap(sel[C7], pin_sync_r[C7], `PF_CODE_ALT1);
    sense_nxt.uart3_rx = tap(sel[C6], pin_sync_r[C6], `PF_CODE_ALT2);
    sense_nxt.spi2.mosi = tap(sel[D0], pin_sync_r[D0], `PF_CODE_ALT2);
    sense_nxt.spi2.miso = tap(sel[D1], pin_sync_r[D1], `PF_CODE_ALT2);
    sense_nxt.spi2.sclk = tap(sel[D2], pin_sync_r[D2], `PF_CODE_ALT2);
    sense_nxt.spi2.ss = tap(sel[D3], pin_sync_r[D3], `PF_CODE_ALT2);
  end

  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sense_r <= '0;
    end else begin
      sense_r <= sense_nxt;
    end
  end

  assign o_pin_out = pin_out_r;
  assign o_pin_oe = pin_oe_r;
  assign o_periph_sense = sense_r;

endmodule

`default_nettype wire

// [rtl/pin_function_defs.svh]
// Purpose: offsets, field positions, reset values and codes of the pin function block
// Assumes: included by bare name from the package and the design files
// Notes: registers are one aligned 32-bit word each, data in bits 7:0
`ifndef PIN_FUNCTION_DEFS_SVH
`define PIN_FUNCTION_DEFS_SVH

`define PF_REG_COUNT 17
`define PF_PIN_COUNT 34
`define PF_ADDR_W 8
`define PF_DATA_W 32
`define PF_SEL_W 3
`define PF_HI_LSB 4
`define PF_LO_LSB 0
`define PF_RESET_VALUE 8'h00
`define PF_SEG_PIN_BASE 2

`define PF_OFS_PORT_B_FUNCTION_3 8'h00
`define PF_OFS_PORT_B_FUNCTION_4 8'h04
`define PF_OFS_PORT_C_FUNCTION_1 8'h08
`define PF_OFS_PORT_C_FUNCTION_2 8'h0c
`define PF_OFS_PORT_C_FUNCTION_3 8'h10
`define PF_OFS_PORT_C_FUNCTION_4 8'h14
`define PF_OFS_PORT_D_FUNCTION_1 8'h18
`define PF_OFS_PORT_D_FUNCTION_2 8'h1c
`define PF_OFS_PORT_D_FUNCTION_3 8'h20
`define PF_OFS_PORT_D_FUNCTION_4 8'h24
`define PF_OFS_PORT_E_FUNCTION_1 8'h28
`define PF_OFS_PORT_E_FUNCTION_2 8'h2c
`define PF_OFS_PORT_E_FUNCTION_3 8'h30
`define PF_OFS_PORT_E_FUNCTION_4 8'h34
`define PF_OFS_PORT_F_FUNCTION_1 8'h38
`define PF_OFS_PORT_F_FUNCTION_2 8'h3c
`define PF_OFS_PORT_F_FUNCTION_3 8'h40
`define PF_OFS_RESERVED_STATUS 8'h44

`define PF_CODE_PORT 3'h0
`define PF_CODE_ALT1 3'h1
`define PF_CODE_ALT2 3'h2
`define PF_CODE_ALT3 3'h3

`endif

// [rtl/pin_function_pkg.sv]
// Purpose: types shared by the pin function block
// Assumes: pin_function_defs.svh for the sizes
// Notes: drive bundles go peripheral to pin, sense bundles pin to peripheral
`include "pin_function_defs.svh"

package pin_function_pkg;

  typedef logic [`PF_SEL_W-1:0] pin_sel_t;

  typedef struct packed {
    logic out;
    logic oe;
  } drive_t;

  typedef struct packed {
    drive_t mosi;
    drive_t miso;
    drive_t sclk;
    drive_t ss;
  } spi_drive_t;

  typedef struct packed {
    logic mosi;
    logic miso;
    logic sclk;
    logic ss;
  } spi_sense_t;

  typedef struct packed {
    drive_t spi0_sclk;
    drive_t spi0_ss;
    drive_t i2c_scl;
    drive_t i2c_sda;
    spi_drive_t spi1;
    spi_drive_t spi2;
    drive_t timer_channel_0;
    drive_t timer_channel_1;
    logic uart1_tx;
    logic uart2_tx;
    logic uart3_tx;
    logic system_clock_output;
    logic [31:0] segment_line;
  } periph_drive_t;

  typedef struct packed {
    logic [7:0] keyboard_input;
    logic spi0_sclk;
    logic spi0_ss;
    logic i2c_scl;
    logic i2c_sda;
    spi_sense_t spi1;
    spi_sense_t spi2;
    logic timer_channel_0;
    logic timer_channel_1;
    logic pulse_counter_channel_0;
    logic pulse_counter_channel_1;
    logic uart1_rx;
    logic uart2_rx;
    logic uart3_rx;
  } periph_sense_t;

endpackage

// [rtl/pin_function_regs.sv]
// Purpose: classic wishbone slave holding the pin function registers
// Assumes: reset already synchronised by the top
// Notes: one wait state; writes land on the edge that samples ack
`timescale 1ns/1ps
`default_nettype none
`include "pin_function_defs.svh"

module pin_function_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`PF_ADDR_W-1:0] i_wb_adr,
  input wire logic [`PF_DATA_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic i_reserved_any,
  output logic [`PF_DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  output pin_function_pkg::pin_sel_t [`PF_PIN_COUNT-1:0] o_sel
);

  localparam int REGS = `PF_REG_COUNT;

  logic [7:0] fn_r [REGS];
  logic ack_r;
  logic [`PF_DATA_W-1:0] rdat_r;
  logic [5:0] dec;
  logic [4:0] idx;
  logic hit;
  logic req;

  // offset to register index; unmapped gives hit low
  function automatic logic [5:0] decode(input logic [`PF_ADDR_W-1:0] a);
    case (a)
      `PF_OFS_PORT_B_FUNCTION_3: decode = {1'b1, 5'd0};
      `PF_OFS_PORT_B_FUNCTION_4: decode = {1'b1, 5'd1};
      `PF_OFS_PORT_C_FUNCTION_1: decode = {1'b1, 5'd2};
      `PF_OFS_PORT_C_FUNCTION_2: decode = {1'b1, 5'd3};
      `PF_OFS_PORT_C_FUNCTION_3: decode = {1'b1, 5'd4};
      `PF_OFS_PORT_C_FUNCTION_4: decode = {1'b1, 5'd5};
      `PF_OFS_PORT_D_FUNCTION_1: decode = {1'b1, 5'd6};
      `PF_OFS_PORT_D_FUNCTION_2: decode = {1'b1, 5'd7};
      `PF_OFS_PORT_D_FUNCTION_3: decode = {1'b1, 5'd8};
      `PF_OFS_PORT_D_FUNCTION_4: decode = {1'b1, 5'd9};
      `PF_OFS_PORT_E_FUNCTION_1: decode = {1'b1, 5'd10};
      `PF_OFS_PORT_E_FUNCTION_2: decode = {1'b1, 5'd11};
      `PF_OFS_PORT_E_FUNCTION_3: decode = {1'b1, 5'd12};
      `PF_OFS_PORT_E_FUNCTION_4: decode = {1'b1, 5'd13};
      `PF_OFS_PORT_F_FUNCTION_1: decode = {1'b1, 5'd14};
      `PF_OFS_PORT_F_FUNCTION_2: decode = {1'b1, 5'd15};
      `PF_OFS_PORT_F_FUNCTION_3: decode = {1'b1, 5'd16};
      default: decode = 6'h00;
    endcase
  endfunction

  assign dec = decode(i_wb_adr);
  assign hit = dec[5];
  assign idx = dec[4:0];
  assign req = i_wb_cyc & i_wb_stb;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // bits 7 and 3 read zero whatever was written
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdat_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      rdat_r <= 32'h0000_0000;
      if (hit) begin
        rdat_r[7:0] <= fn_r[idx] & 8'h77;
      end else if (i_wb_adr == `PF_OFS_RESERVED_STATUS) begin
        rdat_r[0] <= i_reserved_any;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int r = 0; r < REGS; r++) begin
        fn_r[r] <= `PF_RESET_VALUE;
      end
    end else if (req && ack_r && i_wb_we && hit && i_wb_sel[0]) begin
      fn_r[idx] <= i_wb_dat[7:0] & 8'h77;
    end
  end

  always_comb begin
    for (int r = 0; r < REGS; r++) begin
      o_sel[2*r] = fn_r[r][`PF_LO_LSB +: `PF_SEL_W];
      o_sel[2*r+1] = fn_r[r][`PF_HI_LSB +: `PF_SEL_W];
    end
  end

  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;

endmodule

`default_nettype wire

// [verification/pf_checker.sv]
// Purpose: port-level checks of the pin function block
// Assumes: bound to port_pin_function_select, one clock domain
// Notes: a shadow of the B4 field stands in for the hidden register
`timescale 1ns/1ps
`default_nettype none
module pf_checker #(
  parameter int PIN_COUNT = 34
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [PIN_COUNT-1:0] i_pin_in,
  input wire logic [PIN_COUNT-1:0] o_pin_out,
  input wire logic [PIN_COUNT-1:0] o_pin_oe,
  input wire logic [PIN_COUNT-1:0] i_port_out,
  input wire logic [PIN_COUNT-1:0] i_port_oe,
  input wire logic [PIN_COUNT-1:0] o_port_in
);
  logic [2:0] up_r;
  logic [2:0] b4_r;
  wire logic req = i_wb_cyc && i_wb_stb;
  wire logic wr_b4 = req && o_wb_ack && i_wb_we && i_wb_adr == 8'h00 && i_wb_sel[0];
  // synchroniser and internal reset need a few edges before pins are meaningful
  wire logic live = (up_r == 3'h7);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) b4_r <= 3'h0;
    else if (wr_b4) b4_r <= i_wb_dat[2:0];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held past one cycle");
  a_ack_answers_req: assert property (req && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  a_ack_needs_req: assert property (o_wb_ack |-> $past(req))
    else $error("ack without request");
  a_read_masked: assert property (o_wb_ack |->
    o_wb_dat[31:8] == 24'h00_0000 && !o_wb_dat[7] && !o_wb_dat[3])
    else $error("read data has set reserved bits");
  a_rdat_holds: assert property (!$rose(o_wb_ack) |-> $stable(o_wb_dat))
    else $error("read data moved outside an answer");
  a_reset_quiet: assert property ($rose(i_resetn) |-> o_pin_oe == '0)
    else $error("pins driven at reset release");
  a_port_in_live: assert property (live |-> o_port_in == $past(i_pin_in, 2))
    else $error("port input does not follow pin");
  a_port_route: assert property (live && $past(b4_r) == 3'h0 |->
    o_pin_out[0] == $past(i_port_out[0]) && o_pin_oe[0] == $past(i_port_oe[0]))
    else $error("B4 not routed to port");
  a_reserved_quiet: assert property (live && $past(b4_r) > 3'h3 |->
    !o_pin_oe[0] && !o_pin_out[0])
    else $error("B4 driven under reserved code");
  c_write: cover property (req && i_wb_we && o_wb_ack);
  c_read: cover property (req && !i_wb_we && o_wb_ack);
  c_reserved: cover property (b4_r == 3'h4);
endmodule
bind port_pin_function_select pf_checker #(.PIN_COUNT(PIN_COUNT)) pf_checker_i (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .i_port_out(i_port_out), .i_port_oe(i_port_oe), .o_port_in(o_port_in)
);
`default_nettype wire

// [verification/pf_periph_model.sv]
// Purpose: stand-in for the peripherals that drive the shared pins
// Assumes: one clock; the pattern is inverted from one edge after i_step rises until one edge after it falls
// Notes: a mixed pattern, so a wrong route shows as a wrong level
`timescale 1ns/1ps
`default_nettype none
module pf_periph_model (
  input wire logic i_clk,
  input wire logic i_step,
  output pin_function_pkg::periph_drive_t o_drive
);
  localparam logic [63:0] PAT = {4{16'ha5c3}};
  logic flip_r;
  // flipping checks both levels on every segment line
  always_ff @(posedge i_clk) begin
    flip_r <= i_step;
  end
  assign o_drive = pin_function_pkg::periph_drive_t'(flip_r ? ~PAT : PAT);
endmodule
`default_nettype wire

// [verification/tb_port_pin_function_select.sv]
// Purpose: self-checking bench of the pin function block
// Assumes: wishbone answer after one wait state, registered pins
// Notes: reserved codes are written only where the quiet pin is checked
`timescale 1ns/1ps
`default_nettype none
module tb_port_pin_function_select;
  logic clk, rstn, cyc, stb, we, ack, step;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [33:0] pin_in, pin_out, pin_oe, port_out, port_oe, port_in;
  pin_function_pkg::periph_drive_t drv;
  pin_function_pkg::periph_sense_t sense;
  int checks = 0;
  int bad_count = 0;
  int ticks = 0;
  logic [7:0] seg_code [1:16] = '{8'h33, 8'h22, 8'h22, 8'h33, 8'h33, 8'h33, 8'h33, 8'h32,
    8'h22, 8'h11, 8'h11, 8'h22, 8'h22, 8'h11, 8'h11, 8'h11};
  port_pin_function_select port_pin_function_select_i (
    .i_clk(clk), .i_resetn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_port_out(port_out),
    .i_port_oe(port_oe), .o_port_in(port_in), .i_periph_drive(drv), .o_periph_sense(sense));
  pf_periph_model pf_periph_model_i (.i_clk(clk), .i_step(step), .o_drive(drv));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d, bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    ticks++;
    if (ticks == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // holds the request until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk("ack", 1, 0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'h1, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, 4'h0, q);
    chk("read", {24'h00_0000, e}, q);
  endtask
  task automatic t_defaults;
    for (int k = 0; k < 17; k++) rd(8'(4 * k), 8'h00);
    rd(8'h80, 8'h00);
    for (int i = 0; i < 2; i++) begin
      port_out <= i ? 34'h1_5a5a_a5a5 : 34'h2_a5a5_5a5a;
      port_oe <= i ? 34'h2_f0f0_0f0f : 34'h1_0f0f_f0f0;
      idle(2);
      chk("port out", port_out, pin_out);
      chk("port oe", port_oe, pin_oe);
    end
  endtask
  task automatic t_masks;
    logic [31:0] q;
    for (int k = 0; k < 17; k++) wr(8'(4 * k), 8'h88);
    for (int k = 0; k < 17; k++) rd(8'(4 * k), 8'h00);
    wb(1'b1, 8'h04, 8'h33, 4'he, q);
    rd(8'h04, 8'h00);
    wr(8'h80, 8'h11);
    rd(8'h80, 8'h00);
  endtask
  task automatic t_segments;
    for (int k = 1; k < 17; k++) wr(8'(4 * k), seg_code[k]);
    pin_in <= 34'h3_c3c3_5a5a;
    for (int p = 0; p < 2; p++) begin
      step <= !step;
      idle(4);
      chk("port in", pin_in, port_in);
      for (int k = 1; k < 17; k++) begin
        rd(8'(4 * k), seg_code[k]);
        chk("seg out", {drv.segment_line[2*k-1], drv.segment_line[2*k-2]},
          {pin_out[2*k+1], pin_out[2*k]});
        chk("seg oe", 2'b11, {pin_oe[2*k+1], pin_oe[2*k]});
      end
    end
    for (int k = 1; k < 17; k++) wr(8'(4 * k), 8'h00);
  endtask
  task automatic t_inputs;
    logic [33:0] v;
    wr(8'h00, 8'h21);
    wr(8'h04, 8'h22);
    wr(8'h10, 8'h02);
    wr(8'h14, 8'h01);
    wr(8'h18, 8'h11);
    wr(8'h08, 8'h11);
    for (int i = 0; i < 2; i++) begin
      v = i ? 34'h1_a5a5_5a5a : 34'h2_5a5a_a5a5;
      pin_in <= v;
      idle(4);
      chk("keys", {v[0], v[13], v[12]}, {sense.keyboard_input[4], sense.keyboard_input[1],
        sense.keyboard_input[0]});
      chk("select in", v[1], sense.spi0_ss);
      chk("rx", {v[2], v[8], v[10]}, {sense.uart2_rx, sense.uart1_rx,
        sense.pulse_counter_channel_0});
      chk("tx", {drv.uart2_tx, 1'b1, drv.spi0_ss.out, drv.spi0_ss.oe},
        {pin_out[3], pin_oe[3], pin_out[1], pin_oe[1]});
      chk("input oe", 0, {pin_oe[0], pin_oe[2], pin_oe[8], pin_oe[10], pin_oe[13]});
      chk("spi1", {drv.spi1.mosi, drv.spi1.miso}, {pin_out[4], pin_oe[4], pin_out[5],
        pin_oe[5]});
      chk("spi1 in", v[5:4], {sense.spi1.miso, sense.spi1.mosi});
    end
    for (int k = 0; k < 7; k++) wr(8'(4 * k), 8'h00);
  endtask
  task automatic t_reserved;
    wr(8'h00, 8'h44);
    wr(8'h30, 8'h11);
    idle(3);
    chk("quiet oe", 0, {pin_oe[25:24], pin_oe[1:0]});
    chk("quiet out", 0, {pin_out[25:24], pin_out[1:0]});
    chk("live in", pin_in, port_in);
    rd(8'h44, 8'h01);
    wr(8'h00, 8'h00);
    wr(8'h30, 8'h00);
    rd(8'h44, 8'h00);
  endtask
  task automatic t_reset_mid;
    wr(8'h04, 8'h33);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    idle(3);
    rd(8'h04, 8'h00);
    chk("oe after reset", port_oe, pin_oe);
  endtask
  initial begin
    rstn = 1'b0;
    {cyc, stb, we, step} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    pin_in = 34'h0_0000_0000;
    port_out = 34'h0_0000_0000;
    port_oe = 34'h0_0000_0000;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    idle(3);
    t_defaults();
    t_masks();
    t_segments();
    t_inputs();
    t_reserved();
    t_reset_mid();
    test_done();
  end
endmodule
`default_nettype wire
